// ### hw/pit_pkg.sv
/*
 Constants for the periodic interrupt timer: register word indices,
 status/control field positions, reset values and divider codes.
 Assumes a 32-bit AHB-Lite bus, one register per aligned word.
*/
package pit_pkg;
    // Printed offsets are not multiples of four: these are word indices
    localparam logic [7:0] IDX_STATUS_CONTROL = 8'h4B;
    localparam logic [7:0] IDX_COUNT_HIGH = 8'h4C;
    localparam logic [7:0] IDX_COUNT_LOW = 8'h4D;
    localparam logic [7:0] IDX_LIMIT_HIGH = 8'h4E;
    localparam logic [7:0] IDX_LIMIT_LOW = 8'h4F;
    localparam int ADDR_LSB = 2;
    localparam int IDX_W = 8;

    localparam int BIT_WRAP_FLAG = 7;
    localparam int BIT_WRAP_IRQ_ENABLE = 6;
    localparam int BIT_COUNT_HALT = 5;
    localparam int BIT_COUNT_CLEAR = 4;
    localparam int DIV_SEL_LSB = 0;
    localparam int DIV_SEL_W = 3;

    localparam logic [7:0] LIMIT_RESET = 8'hFF;
    localparam logic [15:0] COUNT_ZERO = 16'h0000;
    localparam logic [5:0] PRESCALE_ZERO = 6'h00;
    localparam logic [2:0] DIV_SEL_MAX = 3'h6;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] HTRANS_SEQ = 2'h3;
endpackage : pit_pkg

// ### hw/periodic_irq_timer.sv
/*
 Periodic interrupt timer: 16-bit modulo up-counter behind a prescaler,
 with an AHB-Lite slave for its five byte registers.
 Assumes one bus clock, single word transfers, and that wait, stop and
 break levels come from system logic on the same clock.
*/
//
// Functional notes
// RL1 - Divider code picks bus clock /1 to /64; code 7 also /64.
// RL2 - Count equal to limit sets wrap flag, next tick counts from zero.
// RL3 - Interrupt request only while wrap interrupt enable is one.
// RL4 - Flag clears by status read while set, then zero write; one ignored.
// RL5 - A wrap between that read and the zero write cancels the clear.
// RL6 - Halt bit freezes counter; reset sets it.
// RL7 - Clear bit zeroes counter and prescaler, self-clears, reads zero.
// RL8 - Halt and clear written together leave counter stopped at zero.
// RL9 - High byte read latches low byte until low byte is read.
// RL10 - Counter bytes are read-only, zero on reset and on clear.
// RL11 - Limit high write blocks wrap flag until limit low is written.
// RL12 - Reset sets both limit bytes to all ones.
// RL13 - Reset clears flag, enable, clear bit and divider select.
// RL14 - Wait mode keeps counting, blocks bus access, irq may wake.
// RL15 - Stop mode freezes everything and resumes from the same state.
// RL16 - Break halts the counter.
// RL17 - Break with clear enable low: no status changes, armed clear kept.
// RL18 - Break with clear enable high: flag cleared stays cleared.
// RL19 - Software reads low byte after a high byte read in break.
// RL20 - Software clears counter before rewriting the limit.
// RL21 - Software leaves halt clear before wait if wake is needed.
// RL22 - Sixteen-bit counter; reading never disturbs counting.
// RL23 - Interrupt is flag AND enable, held until cleared.
`timescale 1ns/1ps
module periodic_irq_timer (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic wait_mode,
    input wire logic stop_mode,
    input wire logic break_active,
    input wire logic break_clear_enable,
    output logic irq_request
);

    ////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        logic wrap_flag;
        logic wrap_irq_enable;
        logic count_halt;
        logic [2:0] clock_divider_select;
        logic [15:0] count;
        logic [5:0] prescale;
        logic [7:0] limit_high;
        logic [7:0] limit_low;
        logic [7:0] low_hold;
        logic low_held;
        logic limit_pending;
        logic clear_armed;
        logic dp_active;
        logic dp_write;
        logic [7:0] dp_index;
        logic [31:0] rdata;
    } state_s;

    state_s q;
    state_s next_q;

    // Tick mask: divide by 2^sel, code 7 shares the /64 tap
    function automatic logic [5:0] tick_mask(input logic [2:0] sel);
        logic [2:0] s;
        s = (sel > pit_pkg::DIV_SEL_MAX) ? pit_pkg::DIV_SEL_MAX : sel;
        tick_mask = 6'((7'h01 << s) - 7'h01);
    endfunction : tick_mask

    logic addr_phase;
    logic running;
    logic tick;
    logic at_limit;
    logic wrap_event;
    logic status_locked;
    logic [7:0] status_byte;
    logic [7:0] wbyte;

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = q.rdata;
    assign irq_request = q.wrap_flag & q.wrap_irq_enable; // RL3 RL23 RL14

    // Wait mode makes registers unreachable; stop freezes the bus side too
    assign addr_phase = hsel & hready & htrans[1] & ~wait_mode
        & ~stop_mode; // RL14 RL15
    assign running = ~q.count_halt & ~stop_mode & ~break_active; // RL6 RL15 RL16
    assign tick = running
        & ((q.prescale & tick_mask(q.clock_divider_select)) ==
           (tick_mask(q.clock_divider_select))); // RL1
    assign at_limit = q.count == {q.limit_high, q.limit_low}; // RL22
    assign wrap_event = tick & at_limit & ~q.limit_pending; // RL2 RL11
    // Break with clear enable low freezes status bits
    assign status_locked = break_active & ~break_clear_enable; // RL17 RL18
    assign status_byte = {q.wrap_flag, q.wrap_irq_enable, q.count_halt,
        2'h0, q.clock_divider_select}; // RL7
    assign wbyte = hwdata[7:0];

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        next_q = q;
        // Prescaler and counter
        if (running) begin
            next_q.prescale = 6'(q.prescale + 6'h01);
        end
        if (tick) begin
            next_q.prescale = pit_pkg::PRESCALE_ZERO;
            next_q.count = at_limit ? pit_pkg::COUNT_ZERO
                : 16'(q.count + 16'h0001); // RL2
        end
        if (wrap_event) begin
            next_q.wrap_flag = 1'b1; // RL2
            next_q.clear_armed = 1'b0; // RL5
        end

        // Data phase of previous transfer
        next_q.dp_active = addr_phase;
        next_q.dp_write = hwrite;
        next_q.dp_index = haddr[pit_pkg::ADDR_LSB +: pit_pkg::IDX_W];
        if (addr_phase && !hwrite) begin
            next_q.rdata = 32'h00000000;
            case (haddr[pit_pkg::ADDR_LSB +: pit_pkg::IDX_W])
                pit_pkg::IDX_STATUS_CONTROL: begin
                    next_q.rdata[7:0] = status_byte;
                    if (q.wrap_flag && !status_locked) begin
                        next_q.clear_armed = ~wrap_event; // RL4
                    end
                end
                pit_pkg::IDX_COUNT_HIGH: begin
                    next_q.rdata[7:0] = q.count[15:8];
                    if (!q.low_held) begin
                        next_q.low_hold = q.count[7:0]; // RL9
                        next_q.low_held = 1'b1;
                    end
                end
                pit_pkg::IDX_COUNT_LOW: begin
                    next_q.rdata[7:0] = q.low_held ? q.low_hold
                        : q.count[7:0];
                    next_q.low_held = 1'b0; // RL9 RL19
                end
                pit_pkg::IDX_LIMIT_HIGH: next_q.rdata[7:0] = q.limit_high;
                pit_pkg::IDX_LIMIT_LOW: next_q.rdata[7:0] = q.limit_low;
                default: next_q.rdata = 32'h00000000;
            endcase
        end

        if (q.dp_active && q.dp_write) begin
            case (q.dp_index)
                pit_pkg::IDX_STATUS_CONTROL: begin
                    next_q.wrap_irq_enable = wbyte[pit_pkg::BIT_WRAP_IRQ_ENABLE];
                    next_q.count_halt = wbyte[pit_pkg::BIT_COUNT_HALT]; // RL6
                    next_q.clock_divider_select =
                        wbyte[pit_pkg::DIV_SEL_LSB +: pit_pkg::DIV_SEL_W];
                    // Zero write completes an armed clear; one is ignored
                    if (!wbyte[pit_pkg::BIT_WRAP_FLAG] && q.clear_armed
                        && !wrap_event && !status_locked) begin
                        next_q.wrap_flag = 1'b0; // RL4 RL5 RL17 RL18
                        next_q.clear_armed = 1'b0;
                    end
                    if (wbyte[pit_pkg::BIT_COUNT_CLEAR]) begin
                        next_q.count = pit_pkg::COUNT_ZERO; // RL7 RL8 RL10
                        next_q.prescale = pit_pkg::PRESCALE_ZERO;
                        next_q.low_hold = 8'h00;
                    end
                end
                pit_pkg::IDX_LIMIT_HIGH: begin
                    next_q.limit_high = wbyte;
                    next_q.limit_pending = 1'b1; // RL11
                end
                pit_pkg::IDX_LIMIT_LOW: begin
                    next_q.limit_low = wbyte;
                    next_q.limit_pending = 1'b0; // RL11
                end
                default: next_q.limit_pending = q.limit_pending;
            endcase
        end

        // Stop mode: nothing moves
        if (stop_mode) begin
            next_q = q; // RL15
            next_q.dp_active = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            q <= '0; // RL13 RL10
            q.count_halt <= 1'b1; // RL6
            q.limit_high <= pit_pkg::LIMIT_RESET; // RL12
            q.limit_low <= pit_pkg::LIMIT_RESET; // RL12
        end else begin
            q <= next_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Assertion helpers. gap counts bus clocks since the prescaler last
    // restarted; it bounds the slowest divider without a long repetition.
    logic [6:0] gap;
    logic st_wr;
    logic zero_wr;
    logic clr_wr;
    logic lh_wr;
    logic ll_wr;
    logic rd_hi;
    logic rd_lo;
    logic [7:0] a_index;

    // Data phase writes that really land: stop mode throws them away
    assign st_wr = q.dp_active && q.dp_write && !stop_mode
        && q.dp_index == pit_pkg::IDX_STATUS_CONTROL;
    assign zero_wr = st_wr && !wbyte[pit_pkg::BIT_WRAP_FLAG];
    assign clr_wr = st_wr && wbyte[pit_pkg::BIT_COUNT_CLEAR];
    assign lh_wr = q.dp_active && q.dp_write && !stop_mode
        && q.dp_index == pit_pkg::IDX_LIMIT_HIGH;
    assign ll_wr = q.dp_active && q.dp_write && !stop_mode
        && q.dp_index == pit_pkg::IDX_LIMIT_LOW;
    assign a_index = haddr[pit_pkg::ADDR_LSB +: pit_pkg::IDX_W];
    assign rd_hi = addr_phase && !hwrite
        && a_index == pit_pkg::IDX_COUNT_HIGH;
    assign rd_lo = addr_phase && !hwrite
        && a_index == pit_pkg::IDX_COUNT_LOW;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            gap <= 7'h00;
        end else if (!running
            || next_q.prescale == pit_pkg::PRESCALE_ZERO) begin
            gap <= 7'h00;
        end else begin
            gap <= 7'(gap + 7'h01);
        end
    end

    sequence wrap_s;
        tick && at_limit && !q.limit_pending && !stop_mode;
    endsequence

    sequence zero_s;
        q.count == pit_pkg::COUNT_ZERO && q.wrap_flag;
    endsequence

    sequence parked_s;
        q.count == pit_pkg::COUNT_ZERO ##1 q.count == pit_pkg::COUNT_ZERO;
    endsequence

    wrap_sets_flag_a: assert property (@(posedge hclk) // RL2
        disable iff (!hresetn) wrap_s |=> zero_s)
        else $error("wrap did not flag and restart");

    irq_level_a: assert property (@(posedge hclk) // RL3 RL23
        disable iff (!hresetn) irq_request == (q.wrap_flag && q.wrap_irq_enable))
        else $error("irq not flag and enable");

    irq_gated_a: assert property (@(posedge hclk) // RL3
        disable iff (!hresetn) !q.wrap_irq_enable |-> !irq_request)
        else $error("irq raised while disabled");

    one_write_keeps_a: assert property (@(posedge hclk) // RL4
        disable iff (!hresetn) st_wr && wbyte[pit_pkg::BIT_WRAP_FLAG]
        && q.wrap_flag |=> q.wrap_flag)
        else $error("one write cleared flag");

    zero_clears_a: assert property (@(posedge hclk) // RL4
        disable iff (!hresetn) zero_wr && q.clear_armed && !wrap_event
        && !status_locked |=> !q.wrap_flag)
        else $error("armed zero write kept flag");

    unarmed_keeps_a: assert property (@(posedge hclk) // RL5
        disable iff (!hresetn) !q.clear_armed && q.wrap_flag |=> q.wrap_flag)
        else $error("flag cleared without read");

    wrap_disarms_a: assert property (@(posedge hclk) // RL5
        disable iff (!hresetn) wrap_event |=> !q.clear_armed)
        else $error("clear stayed armed over a wrap");

    halt_holds_a: assert property (@(posedge hclk) // RL6
        disable iff (!hresetn) !running
        |=> $stable(q.count) || q.count == pit_pkg::COUNT_ZERO)
        else $error("halted counter moved");

    halt_write_a: assert property (@(posedge hclk) // RL6
        disable iff (!hresetn) st_wr
        |=> q.count_halt == $past(wbyte[pit_pkg::BIT_COUNT_HALT]))
        else $error("halt bit not written");

    clear_zeroes_a: assert property (@(posedge hclk) // RL7 RL10
        disable iff (!hresetn) clr_wr |=> q.count == pit_pkg::COUNT_ZERO
        && q.prescale == pit_pkg::PRESCALE_ZERO)
        else $error("clear left counter or prescaler");

    clear_keeps_limit_a: assert property (@(posedge hclk) // RL7
        disable iff (!hresetn) clr_wr
        |=> $stable(q.limit_high) && $stable(q.limit_low))
        else $error("clear touched the limit");

    clear_bit_zero_a: assert property (@(posedge hclk) // RL7
        disable iff (!hresetn) q.dp_active && !q.dp_write
        |-> !q.rdata[pit_pkg::BIT_COUNT_CLEAR]
        || q.dp_index != pit_pkg::IDX_STATUS_CONTROL)
        else $error("clear bit read as one");

    halt_clear_park_a: assert property (@(posedge hclk) // RL8
        disable iff (!hresetn) clr_wr && wbyte[pit_pkg::BIT_COUNT_HALT]
        |=> parked_s)
        else $error("halt and clear did not park at zero");

    hold_take_a: assert property (@(posedge hclk) // RL9
        disable iff (!hresetn) rd_hi && !q.low_held && !clr_wr
        |=> q.low_held && q.low_hold == $past(q.count[7:0]))
        else $error("high read did not latch low byte");

    hold_keep_a: assert property (@(posedge hclk) // RL9
        disable iff (!hresetn) rd_hi && q.low_held && !clr_wr
        |=> $stable(q.low_hold))
        else $error("second high read refreshed low byte");

    hold_release_a: assert property (@(posedge hclk) // RL9
        disable iff (!hresetn) rd_lo |=> !q.low_held)
        else $error("low read did not release hold");

    pending_set_a: assert property (@(posedge hclk) // RL11
        disable iff (!hresetn) lh_wr |=> q.limit_pending)
        else $error("limit high write did not block");

    pending_clear_a: assert property (@(posedge hclk) // RL11
        disable iff (!hresetn) ll_wr |=> !q.limit_pending)
        else $error("limit low write did not unblock");

    pending_blocks_a: assert property (@(posedge hclk) // RL11
        disable iff (!hresetn) q.limit_pending && !q.wrap_flag |=> !q.wrap_flag)
        else $error("flag set while limit pending");

    wait_no_access_a: assert property (@(posedge hclk) // RL14
        disable iff (!hresetn) wait_mode |=> !q.dp_active)
        else $error("bus access taken in wait");

    wait_counts_a: assert property (@(posedge hclk) // RL14
        disable iff (!hresetn) wait_mode && tick && !at_limit && !clr_wr
        |=> q.count == 16'($past(q.count) + 16'h0001))
        else $error("counter stalled in wait");

    stop_freeze_a: assert property (@(posedge hclk) // RL15
        disable iff (!hresetn) stop_mode |=> $stable(q.count)
        && $stable(q.prescale) && $stable(q.wrap_flag))
        else $error("state moved in stop");

    break_halt_a: assert property (@(posedge hclk) // RL16
        disable iff (!hresetn) break_active && !clr_wr |=> $stable(q.count))
        else $error("counter moved in break");

    break_locks_a: assert property (@(posedge hclk) // RL17
        disable iff (!hresetn) break_active && !break_clear_enable
        && q.wrap_flag |=> q.wrap_flag)
        else $error("flag cleared in break");

    armed_kept_a: assert property (@(posedge hclk) // RL17
        disable iff (!hresetn) status_locked && q.clear_armed
        |=> q.clear_armed)
        else $error("armed clear lost in break");

    break_clear_a: assert property (@(posedge hclk) // RL18
        disable iff (!hresetn) zero_wr && break_active && break_clear_enable
        && q.clear_armed |=> !q.wrap_flag)
        else $error("enabled clear ignored in break");

    divider_rate_a: assert property (@(posedge hclk) // RL1
        disable iff (!hresetn) gap <= 7'h3F)
        else $error("divider too slow");

    div_one_a: assert property (@(posedge hclk) // RL1
        disable iff (!hresetn) q.clock_divider_select == 3'h0 && running
        |-> tick)
        else $error("undivided clock missed a tick");

    count_step_a: assert property (@(posedge hclk) // RL22
        disable iff (!hresetn) tick && !at_limit && !clr_wr
        |=> q.count == 16'($past(q.count) + 16'h0001))
        else $error("counter did not step by one");
endmodule : periodic_irq_timer

// ### sim/tb.sv
/*
 Self-checking bench for periodic_irq_timer: AHB-Lite master tasks and
 one task per scenario. Assumes the zero wait state slave of the design.
*/
`timescale 1ns/1ps
module tb;
    localparam logic [7:0] ST = pit_pkg::IDX_STATUS_CONTROL;
    localparam logic [7:0] CH = pit_pkg::IDX_COUNT_HIGH;
    localparam logic [7:0] CL = pit_pkg::IDX_COUNT_LOW;
    localparam logic [7:0] LH = pit_pkg::IDX_LIMIT_HIGH;
    localparam logic [7:0] LL = pit_pkg::IDX_LIMIT_LOW;
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq_request;
    logic wait_mode, stop_mode, break_active, break_clear_enable;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [7:0] v, h, l;
    logic [15:0] cnt, e;
    int n_mismatch, num_checks;

    periodic_irq_timer u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .wait_mode(wait_mode),
        .stop_mode(stop_mode), .break_active(break_active),
        .break_clear_enable(break_clear_enable), .irq_request(irq_request));

    initial begin
        hclk = 1'b0;
        forever #2.5 hclk = ~hclk;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic cyc(input int n);
        repeat (n) @(posedge hclk);
    endtask : cyc
    task automatic addr(input logic [7:0] idx, input logic w);
        hsel <= 1'b1;
        haddr <= {22'h000000, idx, 2'b00};
        htrans <= pit_pkg::HTRANS_NONSEQ;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
    endtask : addr
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        addr(idx, 1'b1);
        hwdata <= {24'h000000, d};
        do @(posedge hclk); while (hreadyout !== 1'b1);
    endtask : wr
    task automatic rd(input logic [7:0] idx, output logic [7:0] d);
        addr(idx, 1'b0);
        do @(posedge hclk); while (hreadyout !== 1'b1);
        d = hrdata[7:0];
    endtask : rd
    task automatic rdc();
        rd(CH, h);
        rd(CL, l);
        cnt = {h, l};
    endtask : rdc
    task automatic chk(input string what, input logic [15:0] seen, exp);
        num_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic ok(input string what, input logic c);
        chk(what, {15'h0000, c}, 16'h0001);
    endtask : ok

    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        rd(ST, v);
        chk("status reset", v, 8'h20);
        rdc();
        chk("count reset", cnt, 16'h0000);
        rd(LH, h);
        rd(LL, l);
        chk("limit reset", {h, l}, 16'hFFFF);
        rd(8'h50, v);
        chk("unmapped read", v, 8'h00);
    endtask : t_reset
    task automatic t_div();
        for (int s = 0; s < 8; s++) begin
            wr(ST, 8'h10 | 8'(s));
            cyc(512);
            rdc();
            e = 16'(512 >> ((s == 7) ? 6 : s));
            ok("divided count", cnt + 16'h0001 >= e && cnt <= e + 16'h0002);
        end
        wr(ST, 8'h10);
        rd(CH, h);
        cyc(100);
        rd(CL, l);
        ok("held low byte", l < 8'h08);
        rd(CL, l);
        ok("released low byte", l > 8'h60);
    endtask : t_div
    task automatic t_wrap();
        wr(LH, 8'h00);
        wr(LL, 8'h04);
        wr(ST, 8'h10);
        cyc(20);
        rd(ST, v);
        chk("wrap flag", v, 8'h80);
        chk("irq disabled", irq_request, 1'b0);
        rdc();
        ok("restart from zero", cnt <= 16'h0004);
        wr(ST, 8'h40);
        // The enable lands at the write's last edge: look one edge later
        cyc(1);
        chk("irq enabled", irq_request, 1'b1);
        wr(ST, 8'hE0);
        rd(ST, v);
        chk("one write keeps flag", v, 8'hE0);
        wr(ST, 8'h60);
        rd(ST, v);
        chk("flag cleared", v, 8'h60);
        chk("irq dropped", irq_request, 1'b0);
        wr(ST, 8'h40);
        cyc(20);
        wr(ST, 8'hE0);
        rd(ST, v);
        // A wrap lands between the qualifying read and the zero write
        wr(ST, 8'hC0);
        cyc(20);
        wr(ST, 8'hE0);
        wr(ST, 8'h60);
        rd(ST, v);
        chk("late wrap kept", v, 8'hE0);
        wr(ST, 8'h60);
        wr(LH, 8'h00);
        wr(ST, 8'h00);
        cyc(300);
        rd(ST, v);
        chk("wrap blocked", v, 8'h00);
        wr(LL, 8'h04);
        cyc(20);
        rd(ST, v);
        chk("wrap unblocked", v, 8'h80);
        // A wrap in this gap disarms the clear, so the flag must survive
        cyc(5);
        wr(ST, 8'h30);
        cyc(10);
        rdc();
        chk("halt and clear", cnt, 16'h0000);
        rd(ST, v);
        chk("clear reads zero", v, 8'hA0);
        rd(LL, v);
        chk("limit untouched", v, 8'h04);
    endtask : t_wrap
    task automatic t_freeze(input logic stop);
        wr(LH, 8'hFF);
        wr(LL, 8'hFF);
        wr(ST, 8'h10);
        if (stop) stop_mode <= 1'b1;
        else break_active <= 1'b1;
        cyc(200);
        stop_mode <= 1'b0;
        break_active <= 1'b0;
        wr(ST, 8'h20);
        rdc();
        ok("frozen count", cnt <= 16'h0008);
    endtask : t_freeze
    task automatic t_break();
        wr(ST, 8'h30);
        wr(LH, 8'h00);
        wr(LL, 8'h04);
        for (int b = 0; b < 2; b++) begin
            wr(ST, 8'h00);
            cyc(20);
            wr(ST, 8'h20);
            rd(ST, v);
            break_clear_enable <= b[0];
            break_active <= 1'b1;
            cyc(2);
            rd(ST, v);
            wr(ST, 8'h20);
            rd(ST, v);
            chk("status in break", v, b ? 8'h20 : 8'hA0);
            break_active <= 1'b0;
            cyc(2);
            if (b == 0) wr(ST, 8'h20);
            rd(ST, v);
            chk("status after break", v, 8'h20);
        end
        break_clear_enable <= 1'b0;
    endtask : t_break
    task automatic t_wait();
        wr(ST, 8'h47);
        wait_mode <= 1'b1;
        // Bus writes are dropped in wait, so the halt here must not land
        wr(ST, 8'h60);
        chk("no early irq", irq_request, 1'b0);
        cyc(400);
        chk("wake irq", irq_request, 1'b1);
        wait_mode <= 1'b0;
        rd(ST, v);
        chk("write ignored", v, 8'hC7);
    endtask : t_wait

    ////////////////////////////////////////////////////////////////////////
    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : conclude
    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h00000000;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h00000000;
        wait_mode = 1'b0;
        stop_mode = 1'b0;
        break_active = 1'b0;
        break_clear_enable = 1'b0;
        cyc(4);
        hresetn <= 1'b1;
        t_reset();
        t_div();
        t_wrap();
        t_freeze(1'b1);
        t_freeze(1'b0);
        t_break();
        t_wait();
        conclude();
    end
    initial begin
        #200000;
        n_mismatch++;
        conclude();
    end
endmodule : tb
